// File: verilog/pma_phy_mgmt_access.sv
// Purpose: avalon-mm register front end for phy management access
// Assumes: one clock, synchronous active-high reset, word-aligned access
// Notes:   every access takes one wait cycle; unmapped reads return zero
//
// Chosen here: the Avalon-MM interface to the registers.

`timescale 1ns/1ps
`default_nettype none

module pma_phy_mgmt_access
	import pma_pkg::*;
(
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst,
	input  wire logic [7:0]        i_avs_address,
	input  wire logic              i_avs_read,
	input  wire logic              i_avs_write,
	input  wire logic [31:0]       i_avs_writedata,
	input  wire logic [3:0]        i_avs_byteenable,
	output logic      [31:0]       o_avs_readdata,
	output logic                   o_avs_waitrequest,
	input  wire logic              i_phy_ack,
	input  wire logic [15:0]       i_phy_rdata,
	output logic                   o_phy_req,
	output logic      [4:0]        o_phy_addr,
	output logic      [4:0]        o_phy_reg,
	output logic                   o_phy_write,
	output logic      [15:0]       o_phy_wdata
);

	// ****************************************************************
	// helpers
	// ****************************************************************

	// word index decode, shared by read and write paths
	// a misaligned address matches nothing, so it cannot alias a register
	function automatic logic reg_hit(input logic [7:0] addr,
	                                 input logic [5:0] idx);
		reg_hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
	endfunction

	// merge write data into the old word under byte enables
	// lets software change one byte without a read-modify-write
	function automatic logic [31:0] be_merge(input logic [31:0] old_w,
	                                         input logic [31:0] new_w,
	                                         input logic [3:0]  be);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				res[b*8 +: 8] = new_w[b*8 +: 8];
		end
		be_merge = res;
	endfunction

	// ****************************************************************
	// declarations
	// ****************************************************************
	// state of the bus front end and of the two software registers
	logic        wait_ff, nxt_wait;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [4:0]  paddr_ff, nxt_paddr;
	logic [4:0]  ridx_ff, nxt_ridx;
	logic        wnr_ff, nxt_wnr;
	logic        busy_ff, nxt_busy;
	logic [15:0] data_ff, nxt_data;

	// combinational decode and the hand-off to the engine
	logic        accept;
	logic        wr_acc;
	logic        wr_data;
	logic [31:0] acc_word;
	logic [31:0] data_word;
	logic [31:0] acc_new;
	logic [31:0] data_new;
	logic        start;
	logic        eng_done;
	logic [15:0] eng_rdata;

	// ****************************************************************
	// bus decode
	// ****************************************************************

	// current register images; reserved bits read as zero
	assign acc_word  = {16'h0000, paddr_ff, ridx_ff, 4'h0, wnr_ff, busy_ff};
	assign data_word = {16'h0000, data_ff};

	// the request takes effect in the cycle waitrequest is low
	assign accept  = (i_avs_read || i_avs_write) && !wait_ff;
	assign wr_acc  = accept && i_avs_write
	                 && reg_hit(i_avs_address, REG_IDX_ACCESS);
	assign wr_data = accept && i_avs_write
	                 && reg_hit(i_avs_address, REG_IDX_DATA);

	assign acc_new  = be_merge(acc_word, i_avs_writedata, i_avs_byteenable);
	assign data_new = be_merge(data_word, i_avs_writedata, i_avs_byteenable);

	// writes while busy are dropped so a running transfer stays intact
	assign start = wr_acc && !busy_ff && acc_new[ACC_BUSY_BIT];

	// ****************************************************************
	// bus handshake and read data
	// ****************************************************************

	// one wait cycle per access; readdata is ready when waitrequest drops
	// trade-off: two cycles per access buy a readdata path from flops
	always_comb
	begin
		nxt_wait  = 1'b1;
		nxt_rdata = rdata_ff;
		if ((i_avs_read || i_avs_write) && wait_ff)
		begin
			nxt_wait = 1'b0;
			if (reg_hit(i_avs_address, REG_IDX_ACCESS))
				nxt_rdata = acc_word;
			else if (reg_hit(i_avs_address, REG_IDX_DATA))
				nxt_rdata = data_word;
			else
				nxt_rdata = RDATA_RST;      // unmapped reads zero
		end
	end

	// registered so readdata and waitrequest leave straight from flops
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			wait_ff  <= 1'b1;
			rdata_ff <= RDATA_RST;
		end
		else
		begin
			wait_ff  <= nxt_wait;
			rdata_ff <= nxt_rdata;
		end
	end

	// ****************************************************************
	// access and data registers
	// ****************************************************************

	// fields are frozen while busy; only the done pulse clears busy
	// done only comes while busy is one, so set and clear never meet
	always_comb
	begin
		nxt_paddr = paddr_ff;
		nxt_ridx  = ridx_ff;
		nxt_wnr   = wnr_ff;
		nxt_busy  = busy_ff;
		nxt_data  = data_ff;
		if (wr_acc && !busy_ff)
		begin
			nxt_paddr = acc_new[ACC_PADDR_MSB:ACC_PADDR_LSB];
			nxt_ridx  = acc_new[ACC_RIDX_MSB:ACC_RIDX_LSB];
			nxt_wnr   = acc_new[ACC_WNR_BIT];
			nxt_busy  = acc_new[ACC_BUSY_BIT];
		end
		if (wr_data && !busy_ff)
			nxt_data = data_new[DATA_MSB:0];
		// read result lands in the same edge that clears busy
		if (eng_done)
		begin
			nxt_busy = 1'b0;
			if (!wnr_ff)
				nxt_data = eng_rdata;
		end
	end

	// all register images reset to zero, busy included
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			paddr_ff <= ACC_PADDR_RST;
			ridx_ff  <= ACC_RIDX_RST;
			wnr_ff   <= ACC_WNR_RST;
			busy_ff  <= ACC_BUSY_RST;
			data_ff  <= DATA_RST;
		end
		else
		begin
			paddr_ff <= nxt_paddr;
			ridx_ff  <= nxt_ridx;
			wnr_ff   <= nxt_wnr;
			busy_ff  <= nxt_busy;
			data_ff  <= nxt_data;
		end
	end

	// ****************************************************************
	// management transaction engine
	// ****************************************************************

	// limitation: the phy address is passed on as written, so software
	// must program 00001 itself or the transfer is never answered
	// fields come straight from the bus word so the engine and the
	// access register capture the same values on the same edge
	pma_mgmt_engine u_engine
	(
		.i_ref_clk   (i_ref_clk),
		.i_rst       (i_rst),
		.i_start     (start),
		.i_paddr     (acc_new[ACC_PADDR_MSB:ACC_PADDR_LSB]),
		.i_ridx      (acc_new[ACC_RIDX_MSB:ACC_RIDX_LSB]),
		.i_write     (acc_new[ACC_WNR_BIT]),
		.i_wdata     (data_ff),
		.i_phy_ack   (i_phy_ack),
		.i_phy_rdata (i_phy_rdata),
		.o_phy_req   (o_phy_req),
		.o_phy_addr  (o_phy_addr),
		.o_phy_reg   (o_phy_reg),
		.o_phy_write (o_phy_write),
		.o_phy_wdata (o_phy_wdata),
		.o_done      (eng_done),
		.o_rdata     (eng_rdata)
	);

	// bus outputs are the registered copies, no logic after the flops
	assign o_avs_waitrequest = wait_ff;
	assign o_avs_readdata    = rdata_ff;

endmodule

`default_nettype wire

// File: verilog/pma_pkg.sv
// Purpose: constants shared by the phy management access block
// Assumes: 32-bit avalon-mm register bus, byte address = 4 * index
// Notes:   register indices are kept as printed, byte address derived
//
// Summary of operation
// - the register index field, bits 10 to 6, picks the phy register used.
// - access bit 1 high writes the data register out, low reads into it.
// - busy stays one for the whole transfer and hardware clears it at end.
// - read data is loaded into the data register no later than busy clear.
// - data register holds 16 bits in 15 to 0, the upper half reads zero.

package pma_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam int          AVS_AW         = 8;
	localparam int          AVS_DW         = 32;
	localparam logic [5:0]  REG_IDX_ACCESS = 6'h06;
	localparam logic [5:0]  REG_IDX_DATA   = 6'h07;

	// ****************************************************************
	// field layout
	// ****************************************************************
	localparam int          ACC_BUSY_BIT   = 0;
	localparam int          ACC_WNR_BIT    = 1;
	localparam int          ACC_RIDX_LSB   = 6;
	localparam int          ACC_RIDX_MSB   = 10;
	localparam int          ACC_PADDR_LSB  = 11;
	localparam int          ACC_PADDR_MSB  = 15;
	localparam int          DATA_MSB       = 15;
	localparam int          FIELD_W        = 5;
	localparam int          PHY_DW         = 16;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [4:0]  ACC_PADDR_RST  = 5'h00;
	localparam logic [4:0]  ACC_RIDX_RST   = 5'h00;
	localparam logic        ACC_WNR_RST    = 1'b0;
	localparam logic        ACC_BUSY_RST   = 1'b0;
	localparam logic [15:0] DATA_RST       = 16'h0000;
	localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

	// address the integrated phy answers at, for reference by software
	localparam logic [4:0]  PHY_ADDR_FIXED = 5'h01;

endpackage

// File: verilog/pma_mgmt_engine.sv
// Purpose: runs one parallel management transaction to the phy
// Assumes: phy register set sits on the same clock, ack is a pulse
// Notes:   request stays high until the phy acknowledges it

`timescale 1ns/1ps
`default_nettype none

module pma_mgmt_engine
	import pma_pkg::*;
(
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst,
	input  wire logic              i_start,
	input  wire logic [4:0]        i_paddr,
	input  wire logic [4:0]        i_ridx,
	input  wire logic              i_write,
	input  wire logic [15:0]       i_wdata,
	input  wire logic              i_phy_ack,
	input  wire logic [15:0]       i_phy_rdata,
	output logic                   o_phy_req,
	output logic      [4:0]        o_phy_addr,
	output logic      [4:0]        o_phy_reg,
	output logic                   o_phy_write,
	output logic      [15:0]       o_phy_wdata,
	output logic                   o_done,
	output logic      [15:0]       o_rdata
);

	// ****************************************************************
	// transaction state
	// ****************************************************************
	typedef enum logic [0:0] {ST_IDLE, ST_REQ} pma_eng_st_t;

	pma_eng_st_t st_ff, nxt_st;
	logic        req_ff, nxt_req;
	logic [4:0]  addr_ff, nxt_addr;
	logic [4:0]  reg_ff, nxt_reg;
	logic        wr_ff, nxt_wr;
	logic [15:0] wdata_ff, nxt_wdata;
	logic        done_ff, nxt_done;
	logic [15:0] rdata_ff, nxt_rdata;

	// next-state: capture on start, hold request until ack
	always_comb
	begin
		nxt_st    = st_ff;
		nxt_req   = req_ff;
		nxt_addr  = addr_ff;
		nxt_reg   = reg_ff;
		nxt_wr    = wr_ff;
		nxt_wdata = wdata_ff;
		nxt_done  = 1'b0;
		nxt_rdata = rdata_ff;
		case (st_ff)
			ST_IDLE:
			begin
				if (i_start)
				begin
					nxt_st    = ST_REQ;
					nxt_req   = 1'b1;
					nxt_addr  = i_paddr;
					nxt_reg   = i_ridx;
					nxt_wr    = i_write;
					nxt_wdata = i_wdata;
				end
			end
			ST_REQ:
			begin
				if (i_phy_ack)
				begin
					nxt_st   = ST_IDLE;
					nxt_req  = 1'b0;
					nxt_done = 1'b1;
					// write ack carries no data, keep the last read value
					if (!wr_ff)
						nxt_rdata = i_phy_rdata;
				end
			end
			default:
			begin
				nxt_st  = ST_IDLE;
				nxt_req = 1'b0;
			end
		endcase
	end

	// registers only
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			st_ff    <= ST_IDLE;
			req_ff   <= 1'b0;
			addr_ff  <= ACC_PADDR_RST;
			reg_ff   <= ACC_RIDX_RST;
			wr_ff    <= ACC_WNR_RST;
			wdata_ff <= DATA_RST;
			done_ff  <= 1'b0;
			rdata_ff <= DATA_RST;
		end
		else
		begin
			st_ff    <= nxt_st;
			req_ff   <= nxt_req;
			addr_ff  <= nxt_addr;
			reg_ff   <= nxt_reg;
			wr_ff    <= nxt_wr;
			wdata_ff <= nxt_wdata;
			done_ff  <= nxt_done;
			rdata_ff <= nxt_rdata;
		end
	end

	assign o_phy_req   = req_ff;
	assign o_phy_addr  = addr_ff;
	assign o_phy_reg   = reg_ff;
	assign o_phy_write = wr_ff;
	assign o_phy_wdata = wdata_ff;
	assign o_done      = done_ff;
	assign o_rdata     = rdata_ff;

endmodule

`default_nettype wire

// File: verification/pma_phy_mgmt_access_props.sv
// Purpose: port-level checks of the phy management access block
// Assumes: one clock, synchronous active-high reset
// Notes:   busy is inferred from the phy request seen at the ports
`timescale 1ns/1ps
`default_nettype none
module pma_phy_mgmt_access_props
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	input  wire logic [31:0] o_avs_readdata,
	input  wire logic        o_avs_waitrequest,
	input  wire logic        i_phy_ack,
	input  wire logic [15:0] i_phy_rdata,
	input  wire logic        o_phy_req,
	input  wire logic [4:0]  o_phy_addr,
	input  wire logic [4:0]  o_phy_reg,
	input  wire logic        o_phy_write,
	input  wire logic [15:0] o_phy_wdata
);
	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	logic go;
	logic go_q;
	// accepted busy write; a started request is remembered one cycle
	assign go = i_avs_write && !o_avs_waitrequest && i_avs_address == 8'h18
		&& i_avs_writedata[0];
	always_ff @(posedge i_ref_clk)
		go_q <= i_rst ? 1'b0 : go;
	sequence s_go;
		go && !o_phy_req && !$past(o_phy_req) && !$past(o_phy_req, 2);
	endsequence
	sequence s_ack;
		o_phy_req && i_phy_ack;
	endsequence
	property p_start;
		s_go |=> o_phy_req && o_phy_addr == $past(i_avs_writedata[15:11])
			&& o_phy_reg == $past(i_avs_writedata[10:6])
			&& o_phy_write == $past(i_avs_writedata[1]);
	endproperty
	a_start: assert property (p_start) else $error("bad start");
	property p_rise;
		$rose(o_phy_req) |-> go_q;
	endproperty
	a_rise: assert property (p_rise) else $error("stray request");
	property p_hold;
		o_phy_req && !i_phy_ack |=> o_phy_req
			&& $stable({o_phy_addr, o_phy_reg, o_phy_write, o_phy_wdata});
	endproperty
	a_hold: assert property (p_hold) else $error("request moved");
	property p_drop;
		s_ack |=> !o_phy_req [*2];
	endproperty
	a_drop: assert property (p_drop) else $error("request stuck");
	property p_rd_busy;
		i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h18
			&& $past(o_phy_req) |-> o_avs_readdata[0];
	endproperty
	a_rd_busy: assert property (p_rd_busy) else $error("busy low");
	property p_dhi;
		i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h1c
			|-> o_avs_readdata[31:16] == 16'h0000;
	endproperty
	a_dhi: assert property (p_dhi) else $error("data upper set");
	property p_wait;
		$rose(i_avs_read || i_avs_write) |=> !o_avs_waitrequest ##1
			o_avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("bus answer late");
	property p_wait_one;
		!o_avs_waitrequest |=> o_avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait low twice");
endmodule
bind pma_phy_mgmt_access pma_phy_mgmt_access_props props_u (
	.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.i_phy_ack(i_phy_ack), .i_phy_rdata(i_phy_rdata), .o_phy_req(o_phy_req),
	.o_phy_addr(o_phy_addr), .o_phy_reg(o_phy_reg),
	.o_phy_write(o_phy_write), .o_phy_wdata(o_phy_wdata));
`default_nettype wire

// File: verification/pma_phy_model.sv
// Purpose: phy management register set seen by the access block
// Assumes: same clock as the block, no reset of its own
// Notes:   ack delay comes from the bench; idle read data toggles
`timescale 1ns/1ps
`default_nettype none
module pma_phy_model
	import pma_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_req,
	input  wire logic [4:0]  i_addr,
	input  wire logic [4:0]  i_reg,
	input  wire logic        i_write,
	input  wire logic [15:0] i_wdata,
	input  wire logic [3:0]  i_delay,
	output logic             o_ack,
	output logic      [15:0] o_rdata
);
	// ****************************************************************
	// register set
	// ****************************************************************
	logic [15:0] regs [32];
	logic [3:0]  wait_cnt;
	// known pattern so every index reads back differently
	initial
	begin
		for (int i = 0; i < 32; i++)
			regs[i] = {8'h5a, 3'h0, i[4:0]};
		wait_cnt = 4'h0;
		o_ack = 1'b0;
		o_rdata = 16'h0000;
	end
	// answer only at the fixed address; stale data flips every cycle
	always @(posedge i_ref_clk)
	begin
		o_ack <= 1'b0;
		o_rdata <= ~o_rdata;
		if (i_req && !o_ack && i_addr == PHY_ADDR_FIXED)
		begin
			if (wait_cnt == i_delay)
			begin
				o_ack <= 1'b1;
				wait_cnt <= 4'h0;
				o_rdata <= regs[i_reg];
				if (i_write)
					regs[i_reg] <= i_wdata;
			end
			else
				wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

// File: verification/pma_phy_mgmt_access_test.sv
// Purpose: self-checking bench of the phy management access block
// Assumes: 200 MHz clock, phy model on the management side
// Notes:   all bus traffic goes through the two bus tasks
`timescale 1ns/1ps
`default_nettype none
module pma_phy_mgmt_access_test;
	// ****************************************************************
	// signals and instances
	// ****************************************************************
	logic        ref_clk;
	logic        rst;
	logic [7:0]  av_addr;
	logic        av_rd;
	logic        av_wr;
	logic [31:0] av_wd;
	logic [3:0]  av_be;
	logic [31:0] av_rdata;
	logic        av_wait;
	logic        phy_ack;
	logic [15:0] phy_rdata;
	logic        phy_req;
	logic [4:0]  phy_addr;
	logic [4:0]  phy_reg;
	logic        phy_write;
	logic [15:0] phy_wdata;
	logic [3:0]  phy_dly;
	int          error_cnt;
	int          tests_run;
	localparam logic [7:0] A_ACC = 8'h18;
	localparam logic [7:0] A_DAT = 8'h1c;
	pma_phy_mgmt_access dut_u (.i_ref_clk(ref_clk), .i_rst(rst),
		.i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
		.i_avs_writedata(av_wd), .i_avs_byteenable(av_be),
		.o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
		.i_phy_ack(phy_ack), .i_phy_rdata(phy_rdata), .o_phy_req(phy_req),
		.o_phy_addr(phy_addr), .o_phy_reg(phy_reg), .o_phy_write(phy_write),
		.o_phy_wdata(phy_wdata));
	pma_phy_model phy_u (.i_ref_clk(ref_clk), .i_req(phy_req),
		.i_addr(phy_addr), .i_reg(phy_reg), .i_write(phy_write),
		.i_wdata(phy_wdata), .i_delay(phy_dly), .o_ack(phy_ack),
		.o_rdata(phy_rdata));
	// free-running clock
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// request held until waitrequest is sampled low, then one idle edge
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		av_addr <= a;
		av_wd <= d;
		av_wr <= 1'b1;
		do @(posedge ref_clk); while (av_wait !== 1'b0);
		av_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		av_addr <= a;
		av_rd <= 1'b1;
		do @(posedge ref_clk); while (av_wait !== 1'b0);
		d = av_rdata;
		av_rd <= 1'b0;
		@(posedge ref_clk);
	endtask
	function automatic logic [31:0] acc(input logic [4:0] ri,
		input logic w, input logic b);
		return {16'h0, pma_pkg::PHY_ADDR_FIXED, ri, 4'h0, w, b};
	endfunction
	task automatic poll(output int n);
		logic [31:0] r;
		n = 0;
		do
		begin
			bus_rd(A_ACC, r);
			n++;
		end
		while (r[0] !== 1'b0);
	endtask
	// reset values, then an unmapped place that must stay zero
	task automatic t_regs;
		logic [31:0] r;
		bus_rd(A_ACC, r);
		chk(r, 32'h0);
		bus_rd(A_DAT, r);
		chk(r, 32'h0);
		bus_wr(8'h10, 32'hffff_ffff);
		bus_rd(8'h10, r);
		chk(r, 32'h0);
		// a single byte lane lands alone, the rest of the word stays
		av_be <= 4'h2;
		bus_wr(A_DAT, 32'hffff_ab12);
		av_be <= 4'hf;
		bus_rd(A_DAT, r);
		chk(r, 32'h0000_ab00);
	endtask
	// fields stored without busy must not start a transfer
	task automatic t_store;
		logic [31:0] r;
		bus_wr(A_ACC, acc(5'h03, 1'b1, 1'b0));
		bus_rd(A_ACC, r);
		chk(r, acc(5'h03, 1'b1, 1'b0));
		chk({16'h0, phy_u.regs[3]}, 32'h5a03);
	endtask
	// slow write; a data write while busy has to be ignored
	task automatic t_write(input logic [4:0] ri, input logic [3:0] dly);
		logic [31:0] r;
		int          n;
		phy_dly <= dly;
		bus_wr(A_DAT, 32'hffff_1234);
		bus_rd(A_DAT, r);
		chk(r, 32'h1234);
		bus_wr(A_ACC, acc(ri, 1'b1, 1'b1));
		bus_wr(A_DAT, 32'h0000_beef);
		poll(n);
		chk({31'h0, n > 1}, 32'h1);
		chk({16'h0, phy_u.regs[ri]}, 32'h1234);
		bus_rd(A_DAT, r);
		chk(r, 32'h1234);
		bus_rd(A_ACC, r);
		chk(r, acc(ri, 1'b1, 1'b0));
	endtask
	task automatic t_read(input logic [4:0] ri, input logic [3:0] dly);
		logic [31:0] r;
		int          n;
		phy_dly <= dly;
		bus_wr(A_ACC, acc(ri, 1'b0, 1'b1));
		poll(n);
		bus_rd(A_DAT, r);
		chk(r, {16'h0, 8'h5a, 3'h0, ri});
	endtask
	task test_done;
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ****************************************************************
	// main sequence and watchdog
	// ****************************************************************
	initial
	begin
		rst = 1'b1;
		av_addr = 8'h00;
		av_rd = 1'b0;
		av_wr = 1'b0;
		av_wd = 32'h0;
		av_be = 4'hf;
		phy_dly = 4'h0;
		error_cnt = 0;
		tests_run = 0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_regs();
		t_store();
		t_write(5'h0a, 4'h9);
		t_read(5'h1f, 4'h0);
		t_read(5'h00, 4'h6);
		test_done();
	end
	// whole run needs about a hundred cycles; this bound cuts a hang
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		error_cnt++;
		test_done();
	end
endmodule
`default_nettype wire
